// ### verilog/tpc_calibration.sv
/*
  Two-point weighing calibration: converts converter digits to weight.
  Assumes adc_digits is synchronous to sys_clk and host strobes are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module tpc_calibration #(
  parameter int DIG_W = tpc_pkg::DIG_W,
  parameter int WGT_W = tpc_pkg::WGT_W
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [DIG_W-1:0] adc_digits, // current converter digits
  input wire logic adc_valid, // new digits pulse
  input wire logic rec_wr, // calibration record write pulse
  input wire logic [DIG_W-1:0] rec_zero_dig, // record zero-point digits
  input wire logic [DIG_W-1:0] rec_ref_dig, // record reference digits
  input wire logic [WGT_W-1:0] rec_ref_wgt, // record reference weight
  input wire logic [1:0] rec_sens, // record sensitivity field
  input wire logic cmd_valid, // command pulse
  input wire logic [15:0] cmd_code, // command code
  output logic [WGT_W-1:0] weight, // derived weight
  output logic weight_valid, // new weight pulse
  output logic below_zero, // digits below zero point
  output logic cmd_error, // command error pulse
  output logic cmd_done, // command accepted pulse
  output logic plaus_warn, // captured digits implausible, advisory
  output logic [2:0] sens_mvv, // decoded range in mV/V
  output logic sens_reserved, // reserved range code held
  output logic [DIG_W-1:0] zero_dig, // active zero digits
  output logic [DIG_W-1:0] ref_dig, // active reference digits
  output logic [WGT_W-1:0] ref_wgt // active reference weight
);
  localparam int N_W = DIG_W + WGT_W;
  tpc_pkg::tpc_state_type state;
  logic [DIG_W-1:0] sample;
  logic [DIG_W-1:0] span;
  logic [N_W-1:0] product;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [N_W-1:0] div_quot;
  logic neg;
  logic [DIG_W-1:0] last_dig;

  function automatic logic implausible(input logic [DIG_W-1:0] d);
    implausible = (d > tpc_pkg::DIG_MAX) || (d < tpc_pkg::DIG_BARE);
  endfunction

  // Characteristic store: commands and direct record writes.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_dig <= tpc_pkg::RST_ZERO_DIG;
      ref_dig <= tpc_pkg::RST_REF_DIG;
      ref_wgt <= tpc_pkg::RST_REF_WGT;
      cmd_error <= 1'b0;
      cmd_done <= 1'b0;
      plaus_warn <= 1'b0;
    end else begin
      cmd_error <= 1'b0;
      cmd_done <= 1'b0;
      if (rec_wr) begin
        zero_dig <= rec_zero_dig;
        ref_dig <= rec_ref_dig;
        ref_wgt <= rec_ref_wgt;
        cmd_done <= 1'b1;
        plaus_warn <= implausible(rec_zero_dig) || implausible(rec_ref_dig);
      end else if (cmd_valid) begin
        if (cmd_code == tpc_pkg::CMD_ZERO) begin
          zero_dig <= last_dig;
          cmd_done <= 1'b1;
          plaus_warn <= implausible(last_dig);
        end else if (cmd_code == tpc_pkg::CMD_REF) begin
          if (last_dig == zero_dig) begin
            cmd_error <= 1'b1;
          end else begin
            ref_dig <= last_dig;
            cmd_done <= 1'b1;
            plaus_warn <= implausible(last_dig);
          end
        end else if (cmd_code == tpc_pkg::CMD_SHIFT) begin
          // The span is kept, so a shifted zero moves the reference point with it.
          zero_dig <= last_dig;
          ref_dig <= ref_dig + (last_dig - zero_dig);
          cmd_done <= 1'b1;
        end else begin
          cmd_error <= 1'b1;
        end
      end
    end
  end

  // Latest converter sample, used for captures; the weight takes adc_digits directly.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_dig <= '0;
    end else if (adc_valid) begin
      last_dig <= adc_digits;
    end
  end

  // Sensitivity field decode; only a record write changes it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sens_mvv <= tpc_pkg::MVV_2;
      sens_reserved <= 1'b0;
    end else if (rec_wr) begin
      sens_reserved <= 1'b0;
      case (rec_sens)
        tpc_pkg::SENS_1MV: sens_mvv <= tpc_pkg::MVV_1;
        tpc_pkg::SENS_2MV: sens_mvv <= tpc_pkg::MVV_2;
        tpc_pkg::SENS_4MV: sens_mvv <= tpc_pkg::MVV_4;
        default: sens_reserved <= 1'b1;
      endcase
    end
  end

  // Weight = (digits - zero) * ref_wgt / (ref - zero); below zero clamps to 0.
  assign span = ref_dig - zero_dig;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= tpc_pkg::ST_IDLE;
      sample <= '0;
      neg <= 1'b0;
      product <= '0;
      div_start <= 1'b0;
      weight <= '0;
      weight_valid <= 1'b0;
      below_zero <= 1'b0;
    end else begin
      div_start <= 1'b0;
      weight_valid <= 1'b0;
      case (state)
        tpc_pkg::ST_IDLE: begin
          if (adc_valid && span != '0) begin
            neg <= adc_digits < zero_dig;
            sample <= (adc_digits < zero_dig) ? '0 : adc_digits - zero_dig;
            state <= tpc_pkg::ST_DIV;
          end
        end
        tpc_pkg::ST_DIV: begin
          if (!div_busy && !div_start && product == '0 && !div_done) begin
            product <= N_W'(sample) * N_W'(ref_wgt);
            div_start <= 1'b1;
          end else if (div_done) begin
            weight <= (div_quot > N_W'({WGT_W{1'b1}})) ? {WGT_W{1'b1}} : div_quot[WGT_W-1:0];
            below_zero <= neg;
            weight_valid <= 1'b1;
            product <= '0;
            state <= tpc_pkg::ST_DONE;
          end
        end
        tpc_pkg::ST_DONE: state <= tpc_pkg::ST_IDLE;
        default: state <= tpc_pkg::ST_IDLE;
      endcase
    end
  end

  tpc_divider #(.N_W(N_W), .D_W(DIG_W)) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(div_start),
    .numer(product),
    .denom(span),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  property p_zero_capture;
    @(posedge sys_clk) disable iff (rst)
      (cmd_valid && !rec_wr && cmd_code == tpc_pkg::CMD_ZERO) |=> (zero_dig == $past(last_dig));
  endproperty
  a_zero_capture: assert property (p_zero_capture) else $error("zero capture missed");

  property p_ref_capture;
    @(posedge sys_clk) disable iff (rst)
      (cmd_valid && !rec_wr && cmd_code == tpc_pkg::CMD_REF && last_dig != zero_dig)
        |=> (ref_dig == $past(last_dig)) && cmd_done;
  endproperty
  a_ref_capture: assert property (p_ref_capture) else $error("reference capture missed");

  property p_ref_equal;
    @(posedge sys_clk) disable iff (rst)
      (cmd_valid && !rec_wr && cmd_code == tpc_pkg::CMD_REF && last_dig == zero_dig)
        |=> cmd_error && $stable(ref_dig);
  endproperty
  a_ref_equal: assert property (p_ref_equal) else $error("equal reference accepted");

  property p_record;
    @(posedge sys_clk) disable iff (rst)
      rec_wr |=> (zero_dig == $past(rec_zero_dig)) && (ref_wgt == $past(rec_ref_wgt));
  endproperty
  a_record: assert property (p_record) else $error("record not applied");

  property p_shift;
    @(posedge sys_clk) disable iff (rst)
      (cmd_valid && !rec_wr && cmd_code == tpc_pkg::CMD_SHIFT)
        |=> (zero_dig == $past(last_dig)) && (ref_dig - zero_dig == $past(span));
  endproperty
  a_shift: assert property (p_shift) else $error("zero shift wrong");

  property p_weight_time;
    @(posedge sys_clk) disable iff (rst)
      (state == tpc_pkg::ST_IDLE && adc_valid && span != '0) |-> ##[3:40] weight_valid;
  endproperty
  a_weight_time: assert property (p_weight_time) else $error("weight late");

  property p_below;
    @(posedge sys_clk) disable iff (rst)
      (weight_valid && below_zero) |-> weight == '0;
  endproperty
  a_below: assert property (p_below) else $error("below zero not zero");

  property p_sens;
    @(posedge sys_clk) disable iff (rst)
      (rec_wr && rec_sens == tpc_pkg::SENS_RSV) |=> sens_reserved;
  endproperty
  a_sens: assert property (p_sens) else $error("reserved range missed");

  property p_plaus;
    @(posedge sys_clk) disable iff (rst)
      (cmd_valid && !rec_wr && cmd_code == tpc_pkg::CMD_ZERO
        && (last_dig > tpc_pkg::DIG_MAX || last_dig < tpc_pkg::DIG_BARE))
        |=> plaus_warn;
  endproperty
  a_plaus: assert property (p_plaus) else $error("plausibility warning missed");

  c_weight: cover property (@(posedge sys_clk) disable iff (rst) weight_valid && !below_zero);
  c_ref_err: cover property (@(posedge sys_clk) disable iff (rst) cmd_error);
  c_plaus: cover property (@(posedge sys_clk) disable iff (rst) plaus_warn);
  c_shift: cover property (@(posedge sys_clk) disable iff (rst)
    cmd_valid && cmd_code == tpc_pkg::CMD_SHIFT);
endmodule
`default_nettype wire

// ### verilog/tpc_pkg.sv
/*
  Constants shared by the two-point scale calibration block and its bench; the divider takes only parameters.
  Assumes a single 20 MHz system clock and a synchronous active-high reset.
*/
// How it works
// - The weight and the below_zero flag are computed from the current converter digits.
// - Weight follows a straight line through the zero point and the reference point.
// - Command 1 takes the present digits as zero-point digits, whose weight is always zero.
// - Command 2 takes the present digits and pairs them with the stored reference weight.
// - A written record holding both digit values and the weight takes effect at once.
// - Command 3 moves the zero point so the present load reads as zero.
// - Digits taken by commands 1 and 2 or written in a record are flagged if above 60074 or below 5461, as advice only.
// - The two-bit sensitivity field decodes to 1, 2 or 4 mV/V, with code 11 reserved.
package tpc_pkg;
  localparam int DIG_W = 16;
  localparam int WGT_W = 16;
  localparam logic [15:0] CMD_ZERO = 16'h0001;
  localparam logic [15:0] CMD_REF = 16'h0002;
  localparam logic [15:0] CMD_SHIFT = 16'h0003;
  localparam logic [15:0] DIG_MAX = 16'heaaa;
  localparam logic [15:0] DIG_BARE = 16'h1555;
  localparam logic [15:0] RST_ZERO_DIG = 16'h0000;
  localparam logic [15:0] RST_REF_DIG = 16'hffff;
  localparam logic [15:0] RST_REF_WGT = 16'h0000;
  localparam logic [1:0] SENS_1MV = 2'h0;
  localparam logic [1:0] SENS_2MV = 2'h1;
  localparam logic [1:0] SENS_4MV = 2'h2;
  localparam logic [1:0] SENS_RSV = 2'h3;
  localparam logic [1:0] SENS_DEFAULT = SENS_2MV;
  localparam logic [2:0] MVV_1 = 3'h1;
  localparam logic [2:0] MVV_2 = 3'h2;
  localparam logic [2:0] MVV_4 = 3'h4;
  localparam int DIV_STEPS = 32;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV = 2'b01,
    ST_DONE = 2'b10
  } tpc_state_type;
endpackage

// ### verilog/tpc_divider.sv
/*
  Restoring unsigned divider, one quotient bit per clock.
  Assumes start is only raised while busy is low.
*/
`timescale 1ns/1ns
`default_nettype none
module tpc_divider #(
  parameter int N_W = 32,
  parameter int D_W = 16
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic start, // begin a division
  input wire logic [N_W-1:0] numer, // dividend
  input wire logic [D_W-1:0] denom, // divisor, nonzero
  output logic busy, // division in progress
  output logic done, // one-cycle result pulse
  output logic [N_W-1:0] quot // quotient
);
  logic [N_W-1:0] q;
  logic [D_W:0] rem;
  logic [5:0] cnt;
  logic [D_W:0] trial;
  assign trial = {rem[D_W-1:0], q[N_W-1]} - {1'b0, denom};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      q <= '0;
      rem <= '0;
      cnt <= 6'h00;
      quot <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        q <= numer;
        rem <= '0;
        cnt <= 6'(N_W);
      end else if (busy) begin
        if (!trial[D_W]) begin
          rem <= trial;
          q <= {q[N_W-2:0], 1'b1};
        end else begin
          rem <= {rem[D_W-1:0], q[N_W-1]};
          q <= {q[N_W-2:0], 1'b0};
        end
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= (!trial[D_W]) ? {q[N_W-2:0], 1'b1} : {q[N_W-2:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tpc_host_model.sv
/*
  Host controller model: sends converter samples, calibration records and commands.
  Assumes the bench calls its tasks one at a time from a single process.
*/
`timescale 1ns/1ns
`default_nettype none
module tpc_host_model (
  input wire logic sys_clk, // system clock
  output logic [15:0] adc_digits, // converter digits
  output logic adc_valid, // digits pulse
  output logic rec_wr, // record write pulse
  output logic [15:0] rec_zero_dig, // record zero digits
  output logic [15:0] rec_ref_dig, // record reference digits
  output logic [15:0] rec_ref_wgt, // record reference weight
  output logic [1:0] rec_sens, // record sensitivity code
  output logic cmd_valid, // command pulse
  output logic [15:0] cmd_code // command code
);
  initial begin
    {adc_valid, rec_wr, cmd_valid} = 3'h0;
    {adc_digits, rec_zero_dig, rec_ref_dig, rec_ref_wgt, cmd_code} = 80'h0;
    rec_sens = 2'h1;
  end
  // Released lines carry the inverse of the last value, so stale data never looks fresh.
  task automatic send_adc(input logic [15:0] d);
    @(posedge sys_clk);
    adc_valid <= 1'b1;
    adc_digits <= d;
    @(posedge sys_clk);
    adc_valid <= 1'b0;
    adc_digits <= ~d;
  endtask
  task automatic send_rec(input logic [15:0] z, r, w, input logic [1:0] s);
    @(posedge sys_clk);
    rec_wr <= 1'b1;
    {rec_zero_dig, rec_ref_dig, rec_ref_wgt, rec_sens} <= {z, r, w, s};
    @(posedge sys_clk);
    rec_wr <= 1'b0;
    {rec_zero_dig, rec_ref_dig, rec_ref_wgt, rec_sens} <= ~{z, r, w, s};
  endtask
  task automatic send_cmd(input logic [15:0] c);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
  endtask
endmodule
`default_nettype wire

// ### bench/test_two_point_scale_calibration.sv
/*
  Self-checking bench for the calibration block, driven through the host model.
  Assumes a 20 MHz clock and the one-cycle answer timing of the block.
*/
`timescale 1ns/1ns
`default_nettype none
module test_two_point_scale_calibration;
  logic sys_clk, rst, adc_valid, rec_wr, cmd_valid, weight_valid, below_zero;
  logic cmd_error, cmd_done, plaus_warn, sens_reserved;
  logic [15:0] adc_digits, rec_zero_dig, rec_ref_dig, rec_ref_wgt, cmd_code;
  logic [15:0] weight, zero_dig, ref_dig, ref_wgt, cz, cr, cw;
  logic [1:0] rec_sens;
  logic [2:0] sens_mvv;
  int num_errors, n_compared, i;
  int seed = 32'h4aa38427;
  tpc_host_model tpc_host_model_i (.sys_clk(sys_clk), .adc_digits(adc_digits),
    .adc_valid(adc_valid), .rec_wr(rec_wr), .rec_zero_dig(rec_zero_dig),
    .rec_ref_dig(rec_ref_dig), .rec_ref_wgt(rec_ref_wgt), .rec_sens(rec_sens),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code));
  tpc_calibration tpc_calibration_i (.sys_clk(sys_clk), .rst(rst), .adc_digits(adc_digits),
    .adc_valid(adc_valid), .rec_wr(rec_wr), .rec_zero_dig(rec_zero_dig),
    .rec_ref_dig(rec_ref_dig), .rec_ref_wgt(rec_ref_wgt), .rec_sens(rec_sens),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .weight(weight),
    .weight_valid(weight_valid), .below_zero(below_zero), .cmd_error(cmd_error),
    .cmd_done(cmd_done), .plaus_warn(plaus_warn), .sens_mvv(sens_mvv),
    .sens_reserved(sens_reserved), .zero_dig(zero_dig), .ref_dig(ref_dig),
    .ref_wgt(ref_wgt));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [15:0] exp_w(input logic [15:0] d, z, r, w);
    logic [47:0] q;
    if (d < z) return 16'h0000;
    q = ({32'h0, d - z} * w) / (r - z);
    return (q > 48'hffff) ? 16'hffff : q[15:0];
  endfunction
  function automatic logic exp_pl(input logic [15:0] d);
    return (d > tpc_pkg::DIG_MAX) || (d < tpc_pkg::DIG_BARE);
  endfunction
  task automatic conv(input logic [15:0] d);
    int k;
    tpc_host_model_i.send_adc(d);
    for (k = 0; k < 60 && weight_valid !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (k == 60) begin
      num_errors++;
      end_of_test();
    end
    chk("weight", weight, exp_w(d, cz, cr, cw));
    chk("below_zero", below_zero, 16'(d < cz));
    @(posedge sys_clk);
    #1;
    chk("weight_valid", weight_valid, 16'h0000);
    @(posedge sys_clk);
  endtask
  task automatic docmd(input logic [15:0] c, input logic dn, input logic er);
    tpc_host_model_i.send_cmd(c);
    #1;
    chk("cmd_done", cmd_done, 16'(dn));
    chk("cmd_error", cmd_error, 16'(er));
  endtask
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("sens_mvv", 16'(sens_mvv), 16'h0002);
    chk("ref_dig", ref_dig, 16'hffff);
    chk("zero_dig", zero_dig, 16'h0000);
    for (i = 0; i < 4; i++) begin
      tpc_host_model_i.send_rec(16'h0100, 16'hc000, 16'h2000, i[1:0]);
      #1;
      chk("rec_done", cmd_done, 16'h0001);
      chk("sens_rsv", sens_reserved, 16'(i == 3));
      if (i < 3) chk("sens_mvv", 16'(sens_mvv), 16'h0001 << i);
    end
    for (i = 0; i < 8; i++) begin
      cz = 16'($random(seed)) & 16'h3fff;
      cr = cz + 16'h2000 + (16'($random(seed)) & 16'h7fff);
      cw = 16'h1000 | 16'($random(seed));
      tpc_host_model_i.send_rec(cz, cr, cw, tpc_pkg::SENS_2MV);
      #1;
      chk("zero_dig", zero_dig, cz);
      chk("ref_dig", ref_dig, cr);
      chk("ref_wgt", ref_wgt, cw);
      chk("plaus", plaus_warn, 16'(exp_pl(cz) || exp_pl(cr)));
      conv(cz);
      conv(cr);
      conv(16'($random(seed)));
      conv(cz - 16'h0001);
    end
    // Capture sequence in host order: record, empty zero, load, reference.
    cz = 16'h03e8;
    cr = 16'hc350;
    cw = 16'h03e8;
    tpc_host_model_i.send_rec(cz, cr, cw, tpc_pkg::SENS_2MV);
    conv(16'h1e78);
    docmd(tpc_pkg::CMD_ZERO, 1'b1, 1'b0);
    cz = 16'h1e78;
    chk("zero_dig", zero_dig, cz);
    conv(16'h1e78);
    conv(16'heaaa);
    docmd(tpc_pkg::CMD_REF, 1'b1, 1'b0);
    cr = 16'heaaa;
    chk("ref_dig", ref_dig, cr);
    chk("ref_wgt", ref_wgt, cw);
    chk("plaus", plaus_warn, 16'h0000);
    conv(16'h7530);
    conv(cz);
    docmd(tpc_pkg::CMD_REF, 1'b0, 1'b1);
    chk("ref_kept", ref_dig, cr);
    conv(16'h1f40);
    docmd(tpc_pkg::CMD_SHIFT, 1'b1, 1'b0);
    cz = 16'h1f40;
    cr = 16'heb72;
    chk("zero_dig", zero_dig, cz);
    chk("ref_dig", ref_dig, cr);
    conv(16'h1f40);
    conv(16'h1388);
    docmd(tpc_pkg::CMD_ZERO, 1'b1, 1'b0);
    chk("plaus", plaus_warn, 16'h0001);
    docmd(16'h0007, 1'b0, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
